// ===== design/admbi_pkg.sv
package admbi_pkg;
  // register layout
  localparam int unsigned BYTE_W        = 8;
  localparam int unsigned CHAN_W        = 4;
  localparam int unsigned PORT_W        = 6;
  localparam int unsigned START_BIT     = 8;   // start bit in control high byte
  localparam int unsigned STATUS_BIT    = 15;  // status bit in result high byte
  localparam int unsigned NUM_CHANNELS  = 12;
  localparam logic [3:0]  CHAN_RESET    = 4'h0;
  // conversion timing in bus clock cycles
  localparam int unsigned SAMPLE_CYCLES = 12;
  localparam int unsigned CONV_CYCLES   = 32;
  localparam logic [5:0]  CONV_LAST     = 6'h1f;
  // register select codes
  localparam logic        SEL_RESULT    = 1'b0;
  localparam logic        SEL_DIGITAL   = 1'b1;
  localparam logic        SEL_CONTROL   = 1'b1;
  typedef enum logic {admbi_write_t_w, admbi_read_t_r} admbi_dir_t;
endpackage : admbi_pkg

// ===== design/admbi_if.sv
`timescale 1ns/100ps
interface admbi_if;
  logic       ref_clk;
  logic       resetn;
  logic       select_n;
  logic       read_not_write;
  logic       register_select_line;
  logic [7:0] data_from_host;
  logic       host_oe_n;
  logic [7:0] data_from_dev;
  logic       dev_oe_n;
  modport dev  (input ref_clk, resetn, select_n, read_not_write, register_select_line,
                data_from_host, host_oe_n, output data_from_dev, dev_oe_n);
  modport host (input ref_clk, data_from_dev, dev_oe_n, output resetn, select_n,
                read_not_write, register_select_line, data_from_host, host_oe_n);
endinterface : admbi_if

// ===== design/admbi_device.sv
`timescale 1ns/100ps
module admbi_device
  import admbi_pkg::*;
#(
  parameter int unsigned SAMPLE_LEN = SAMPLE_CYCLES,  // hold phase length in bus clocks
  parameter int unsigned CONV_LEN   = CONV_CYCLES     // whole conversion in bus clocks
)
(
  admbi_if.dev                 bus,
  input  wire logic [5:0]      shared_input_port,
  input  wire logic [7:0]      sample_code,
  output logic [3:0]           channel_select_field,
  output logic                 conversion_busy,
  output logic                 sample_hold
);
  logic       ptr_low_q;
  logic       start_q;
  logic [3:0] chan_q;
  logic       status_q;
  logic [7:0] result_q;
  logic       busy_q;
  logic [5:0] cnt_q;
  logic       wr_sel;
  logic       rd_sel;
  logic       go;
  logic       conv_done;
  // byte lanes presented to the read mux
  logic [7:0] result_hi;
  logic [7:0] result_lo;
  logic [7:0] digital_hi;
  logic [7:0] digital_lo;

  // last count of the sequencer; the counter is six bits wide
  localparam logic [5:0] LAST_CNT = 6'(CONV_LEN - 1);

  // refuse lengths that the six-bit counter cannot serve
  if (CONV_LEN < 2 || CONV_LEN > 64) begin : g_bad_conv_len
    $error("conversion length must lie between 2 and 64 clocks");
  end
  // the sample window must close before the conversion ends
  if (SAMPLE_LEN < 1 || SAMPLE_LEN >= CONV_LEN) begin : g_bad_sample_len
    $error("sample phase must be shorter than the conversion");
  end
  // the register layout assumes a byte-wide bus and a nibble channel field
  if (BYTE_W != 8 || CHAN_W != 4 || PORT_W != 6) begin : g_bad_layout
    $error("register layout constants do not fit the byte lanes");
  end
  // the start bit must sit in the high byte of the control register
  if (START_BIT < BYTE_W || START_BIT >= 2 * BYTE_W) begin : g_bad_start_bit
    $error("start bit must lie in the high byte");
  end
  // the status bit is placed at the top of the result high byte
  if (STATUS_BIT != 2 * BYTE_W - 1) begin : g_bad_status_bit
    $error("status bit must be the top bit of the high byte");
  end
  // the channel field must be wide enough to reach every input
  if ((1 << CHAN_W) < NUM_CHANNELS) begin : g_bad_chan_w
    $error("channel field too narrow for the multiplexer");
  end

  // decode; select high ignores the bus
  assign wr_sel = !bus.select_n && bus.read_not_write == admbi_write_t_w
                  && bus.register_select_line == SEL_CONTROL;
  assign rd_sel = !bus.select_n && bus.read_not_write == admbi_read_t_r;
  // a start written in the high byte fires after the write cycle ends
  assign go = start_q && !wr_sel;

  // byte pointer, set to the low byte by every selected cycle; a deselected cycle in between
  // is what lets back-to-back accesses start on the high byte again
  always_ff @(posedge bus.ref_clk or negedge bus.resetn) begin
    if (!bus.resetn) begin
      ptr_low_q <= 1'b0;
    end else if (!bus.select_n) begin
      ptr_low_q <= 1'b1;
    end else begin
      ptr_low_q <= 1'b0;
    end
  end

  // start bit lives in the high byte, so a one-byte write can start a
  // conversion on the channel already selected; it drops once the write ends
  always_ff @(posedge bus.ref_clk or negedge bus.resetn) begin
    if (!bus.resetn) begin
      start_q <= 1'b0;
    end else if (wr_sel) begin
      if (!ptr_low_q) begin
        start_q <= bus.data_from_host[START_BIT-BYTE_W];
      end
    end else begin
      start_q <= 1'b0;
    end
  end

  // channel field lives in the low byte, so only a two-byte write moves the
  // multiplexer; the rest of the low byte and all of the high byte but the start bit are dropped
  always_ff @(posedge bus.ref_clk or negedge bus.resetn) begin
    if (!bus.resetn) begin
      chan_q <= CHAN_RESET;
    end else if (wr_sel && ptr_low_q) begin
      chan_q <= bus.data_from_host[CHAN_W-1:0];
    end
  end

  // conversion timeline: the first busy cycles hold the input, the rest
  // approximate; the host must keep the clock running throughout
  // the last sequencer cycle latches the result and raises status together
  assign conv_done = busy_q && cnt_q == LAST_CNT;

  // busy flag: raised by a start, dropped after the last count
  always_ff @(posedge bus.ref_clk or negedge bus.resetn) begin
    if (!bus.resetn) begin
      busy_q <= 1'b0;
    end else if (go) begin
      busy_q <= 1'b1;
    end else if (conv_done) begin
      busy_q <= 1'b0;
    end
  end

  // cycle counter; a new start restarts it, which abandons the old conversion
  always_ff @(posedge bus.ref_clk or negedge bus.resetn) begin
    if (!bus.resetn) begin
      cnt_q <= 6'h00;
    end else if (go) begin
      cnt_q <= 6'h00;
    end else if (busy_q) begin
      cnt_q <= cnt_q + 6'h01;
    end
  end

  // result survives reset, so it has no reset branch; a host that resets
  // between conversions still finds the last value
  always_ff @(posedge bus.ref_clk) begin
    if (conv_done) begin
      result_q <= sample_code;
    end
  end

  // status: completion wins over a clearing write in the same cycle
  always_ff @(posedge bus.ref_clk or negedge bus.resetn) begin
    if (!bus.resetn) begin
      status_q <= 1'b0;
    end else if (conv_done) begin
      status_q <= 1'b1;
    end else if (wr_sel || go) begin
      status_q <= 1'b0;
    end
  end

  // byte lanes of the two readable registers
  assign result_hi  = {status_q, 7'h00};
  assign result_lo  = result_q;
  assign digital_hi = {4'h0, chan_q};
  assign digital_lo = {2'h0, shared_input_port};

  // read mux; drivers enabled only for selected reads, and never in reset so
  // a reset in mid-read cannot leave the data lines driven
  always_comb begin
    bus.dev_oe_n = !(rd_sel && bus.resetn);
    if (bus.register_select_line == SEL_RESULT) begin
      bus.data_from_dev = ptr_low_q ? result_lo : result_hi;
    end else begin
      bus.data_from_dev = ptr_low_q ? digital_lo : digital_hi;
    end
  end

  assign channel_select_field = chan_q;
  assign conversion_busy      = busy_q;
  assign sample_hold          = busy_q && cnt_q < 6'(SAMPLE_LEN);
endmodule : admbi_device

// ===== design/admbi_host.sv
`timescale 1ns/100ps
// host end: one or two byte accesses on request
module admbi_host
  import admbi_pkg::*;
(
  admbi_if.host                bus,
  input  wire logic            ref_clk,
  input  wire logic            resetn,
  input  wire logic            req,
  input  wire logic            req_read,
  input  wire logic            req_two,
  input  wire logic            req_reg,
  input  wire logic [15:0]     req_wdata,
  output logic                 ack,
  output logic [15:0]          rdata_q
);
  typedef enum logic [1:0] {admbi_idle_t, admbi_hi_t, admbi_lo_t, admbi_gap_t} admbi_hst_t;
  admbi_hst_t  st_q;
  logic        rd_q;
  logic        two_q;
  logic        reg_q;
  logic [15:0] wd_q;

  assign bus.resetn  = resetn;
  assign bus.select_n = !(st_q == admbi_hi_t || st_q == admbi_lo_t);
  assign bus.read_not_write = rd_q;
  assign bus.register_select_line = reg_q;
  assign bus.data_from_host = (st_q == admbi_lo_t) ? wd_q[7:0] : wd_q[15:8];
  assign bus.host_oe_n = rd_q || bus.select_n;
  assign ack = st_q == admbi_gap_t;

  // sequencer; gap cycle lets the pointer return high
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= admbi_idle_t;
      rd_q <= 1'b1;
      two_q <= 1'b0;
      reg_q <= 1'b0;
      wd_q <= 16'h0000;
    end else begin
      unique case (st_q)
        admbi_idle_t: begin
          if (req) begin
            st_q <= admbi_hi_t;
            rd_q <= req_read;
            two_q <= req_two;
            reg_q <= req_reg;
            wd_q <= req_wdata;
          end
        end
        admbi_hi_t: st_q <= two_q ? admbi_lo_t : admbi_gap_t;
        admbi_lo_t: st_q <= admbi_gap_t;
        admbi_gap_t: st_q <= admbi_idle_t;
      endcase
    end
  end

  // capture read bytes
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 16'h0000;
    end else if (rd_q && st_q == admbi_hi_t) begin
      rdata_q[15:8] <= bus.data_from_dev;
    end else if (rd_q && st_q == admbi_lo_t) begin
      rdata_q[7:0] <= bus.data_from_dev;
    end
  end
endmodule : admbi_host

// ===== verif/admbi_assertions.sv
`timescale 1ns/100ps
module admbi_checker (
  input wire logic       ref_clk,
  input wire logic       resetn,
  input wire logic       select_n,
  input wire logic       read_not_write,
  input wire logic       register_select_line,
  input wire logic [7:0] data_from_host,
  input wire logic       host_oe_n,
  input wire logic [7:0] data_from_dev,
  input wire logic       dev_oe_n
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // drivers only on during a selected read
  chk_drive_when_read: assert property (
    !dev_oe_n |-> !select_n && read_not_write)
    else $error("device drives outside a selected read");
  chk_read_drives: assert property (!select_n && read_not_write |-> !dev_oe_n)
    else $error("selected read not driven");
  chk_no_clash: assert property (!(!dev_oe_n && !host_oe_n))
    else $error("both ends drive the data lines");
  // reset itself is the cause here, so no disable
  chk_reset_float: assert property (disable iff (1'b0) !resetn |-> dev_oe_n)
    else $error("drivers on during reset");
  chk_status_byte: assert property (
    !select_n && $past(select_n) && read_not_write
    && !register_select_line |-> data_from_dev[6:0] == 7'h00)
    else $error("result high byte has stray bits");
  chk_digital_high: assert property (
    !select_n && $past(select_n) && read_not_write
    && register_select_line |-> data_from_dev[7:4] == 4'h0)
    else $error("digital high byte has stray bits");
  chk_digital_low: assert property (
    !select_n && !$past(select_n) && read_not_write
    && register_select_line |-> data_from_dev[7:6] == 2'b00)
    else $error("digital low byte has stray bits");
  chk_access_short: assert property ($fell(select_n) |-> ##[1:2] select_n)
    else $error("access longer than two bytes");
endmodule : admbi_checker

// ===== verif/admbi_bench.sv
`timescale 1ns/100ps
module adc_mpu_bus_interface_bench;
  import admbi_pkg::*;
  typedef struct packed {
    logic        rd;
    logic        two;
    logic        rs;
    logic [15:0] wd;
    logic [15:0] ex;
  } admbi_row_t;
  logic ref_clk, resetn, req, req_read, req_two, req_reg, ack, busy, hold;
  logic [15:0] req_wdata, rdata_q;
  logic [3:0]  chan;
  int          failures, comparisons, n;
  int          busy_cycles, hold_cycles;
  logic [5:0]  port_pins;
  logic [7:0]  sample_in;
  // rd two rs wdata expected (read data, or channel after a write)
  admbi_row_t  rows [6] = '{'{0,1,1,16'h0007,16'h0007}, '{1,1,1,16'h0000,16'h072a},
    '{0,1,0,16'h0003,16'h0007}, '{0,0,1,16'hfe00,16'h0007}, '{1,0,1,16'h0000,16'h0700},
    '{0,1,1,16'hfefb,16'h000b}};
  admbi_if admbi_if_i ();
  assign admbi_if_i.ref_clk = ref_clk;
  admbi_device admbi_device_i (.bus(admbi_if_i), .shared_input_port(port_pins),
    .sample_code(sample_in),
    .channel_select_field(chan), .conversion_busy(busy), .sample_hold(hold));
  admbi_host admbi_host_i (.bus(admbi_if_i), .ref_clk(ref_clk), .resetn(resetn), .req(req),
    .req_read(req_read), .req_two(req_two), .req_reg(req_reg), .req_wdata(req_wdata),
    .ack(ack), .rdata_q(rdata_q));
  admbi_checker admbi_checker_i (.ref_clk(admbi_if_i.ref_clk), .resetn(admbi_if_i.resetn),
    .select_n(admbi_if_i.select_n), .read_not_write(admbi_if_i.read_not_write),
    .register_select_line(admbi_if_i.register_select_line),
    .data_from_host(admbi_if_i.data_from_host), .host_oe_n(admbi_if_i.host_oe_n),
    .data_from_dev(admbi_if_i.data_from_dev), .dev_oe_n(admbi_if_i.dev_oe_n));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // count the cycles of each conversion phase as the design shows them
  always @(posedge ref_clk) begin
    if (busy === 1'b1) busy_cycles++;
    if (hold === 1'b1) hold_cycles++;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t mismatch got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one request pulse, then a bounded wait for the one-cycle ack
  task automatic do_op(input logic rd, input logic two, input logic rs, input logic [15:0] wd);
    @(posedge ref_clk) #1;
    {req, req_read, req_two, req_reg, req_wdata} = {1'b1, rd, two, rs, wd};
    @(posedge ref_clk) #1;
    req = 1'b0;
    for (n = 0; n < 8 && ack !== 1'b1; n++) @(negedge ref_clk);
    if (ack !== 1'b1) chk(16'hdead, 16'h0000);
  endtask : do_op
  task automatic give_verdict;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  // watchdog far beyond the under two hundred cycles the tests need
  initial begin
    #20000;
    failures++;
    give_verdict();
  end
  initial begin
    {req, req_read, req_two, req_reg, req_wdata, resetn} = '0;
    port_pins = 6'h2a;
    sample_in = 8'h5a;
    repeat (4) @(posedge ref_clk);
    #1 resetn = 1'b1;
    foreach (rows[i]) begin
      do_op(rows[i].rd, rows[i].two, rows[i].rs, rows[i].wd);
      @(negedge ref_clk);
      chk(rows[i].rd ? (rows[i].two ? rdata_q : {rdata_q[15:8], 8'h00}) : {12'h000, chan},
          rows[i].ex);
      $display("row test %0d done", i);
    end
    // single-byte start, then a status read while converting
    do_op(1'b0, 1'b0, 1'b1, 16'h0100);
    do_op(1'b1, 1'b0, 1'b0, 16'h0000);
    chk({8'h00, rdata_q[15:8]}, 16'h0000);
    for (n = 0; n < 60 && busy !== 1'b0; n++) @(negedge ref_clk);
    chk(16'(busy_cycles), 16'(CONV_CYCLES));
    chk(16'(hold_cycles), 16'(SAMPLE_CYCLES));
    do_op(1'b1, 1'b1, 1'b0, 16'h0000);
    chk(rdata_q, 16'h805a);
    // a write with register select low must leave status alone
    do_op(1'b0, 1'b1, 1'b0, 16'h0000);
    do_op(1'b1, 1'b0, 1'b0, 16'h0000);
    chk({rdata_q[15:8], 8'h00}, 16'h8000);
    $display("conversion test done");
    // mid-run reset keeps the result but clears status and channel
    @(posedge ref_clk) #1 resetn = 1'b0;
    @(negedge ref_clk);
    chk({12'h000, chan}, 16'h0000);
    repeat (2) @(posedge ref_clk);
    #1 resetn = 1'b1;
    do_op(1'b1, 1'b1, 1'b0, 16'h0000);
    chk(rdata_q, 16'h005a);
    // the digital register follows the port pins as they change
    @(posedge ref_clk) #1 port_pins = 6'h15;
    do_op(1'b1, 1'b1, 1'b1, 16'h0000);
    chk(rdata_q, 16'h0015);
    $display("reset test done");
    // full-scale conversion; a read meanwhile shows the old result
    @(posedge ref_clk) #1 sample_in = 8'hff;
    do_op(1'b0, 1'b0, 1'b1, 16'h0100);
    do_op(1'b1, 1'b1, 1'b0, 16'h0000);
    chk(rdata_q, 16'h005a);
    for (n = 0; n < 60 && busy !== 1'b0; n++) @(negedge ref_clk);
    do_op(1'b1, 1'b1, 1'b0, 16'h0000);
    chk(rdata_q, 16'h80ff);
    // a one-byte control write clears status
    do_op(1'b0, 1'b0, 1'b1, 16'h0000);
    do_op(1'b1, 1'b0, 1'b0, 16'h0000);
    chk({rdata_q[15:8], 8'h00}, 16'h0000);
    $display("status clear test done");
    give_verdict();
  end
endmodule : adc_mpu_bus_interface_bench
